// ===== inc/dbs_mux_if.sv
// lane routing signals shared by the sequencer and its two muxes
// assumes purely combinational muxes behind it
`timescale 1ns/1ns
interface dbs_mux_if;
  logic [1:0] siz;
  logic [1:0] ofs;
  logic [1:0] ack;
  logic [31:0] opnd;
  logic [31:0] lanes_out;
  logic [31:0] lanes_in;
  logic [31:0] merged;
  logic [2:0] cnt;
  modport wr (input siz, ofs, opnd, output lanes_out);
  modport rd (input siz, ofs, ack, opnd, lanes_in, output merged, cnt);
endinterface

// ===== inc/dbs_pkg.sv
// constants and types for the dynamic bus sizing data multiplexer
// assumes a single core clock and synchronous active-high reset
package dbs_pkg;
  typedef logic [1:0] dbs_siz_t;
  typedef logic [1:0] dbs_ack_t;
  // remaining-size codes
  localparam dbs_siz_t SIZ_LONG = 2'h0;
  localparam dbs_siz_t SIZ_BYTE = 2'h1;
  localparam dbs_siz_t SIZ_WORD = 2'h2;
  localparam dbs_siz_t SIZ_THREE = 2'h3;
  // acknowledge pin pair {hi_n, lo_n}
  localparam dbs_ack_t ACK_PORT32 = 2'h0;
  localparam dbs_ack_t ACK_PORT16 = 2'h1;
  localparam dbs_ack_t ACK_PORT8 = 2'h2;
  localparam dbs_ack_t ACK_WAIT = 2'h3;
  // port widths in byte lanes
  localparam logic [2:0] LANES_32 = 3'h4;
  localparam logic [2:0] LANES_16 = 3'h2;
  localparam logic [2:0] LANES_8 = 3'h1;
  // reset values
  localparam logic [31:0] ADDR_RST = 32'h0;
  localparam logic [31:0] DATA_RST = 32'h0;
  localparam logic [2:0] LEFT_RST = 3'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10
  } dbs_state_t;
endpackage

// ===== rtl/dbs_data_mux.sv
// bus-master sequencer with dynamic bus sizing and byte lane muxing
// assumes slaves on fixed lanes answering with an active-low ack pair
//
// Overview of operation
// - remaining-size pins show bytes still to move: 01,10,11,00 for 1..4
// - size is an upper bound; a cycle may move fewer bytes
// - upper address holds long-word base, low two bits the byte offset
// - low address bits encode offset plus zero to plus three bytes
// - any operand byte can reach any lane, chosen by size and offset
// - aligned case puts the most significant byte on lanes 24..31
// - reads latch only the defined bytes per port width and offset
// - writes replicate operand bytes across lanes for every port width
// - aligned long write to word port ends on high ack alone
// - then a new cycle: one word left, offset 10, low bytes on top
// - word write to byte port takes two one-byte cycles, sizes 2 then 1
// - operand bytes numbered 0 msb to 3 lsb; word 2-3, byte 3
`timescale 1ns/1ns
module dbs_data_mux (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire dbs_pkg::dbs_siz_t req_size,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic resp_done,
  output logic [31:0] resp_rdata,
  output logic [31:0] bus_addr,
  output logic remaining_size_hi,
  output logic remaining_size_lo,
  output logic bus_strobe,
  output logic bus_read,
  output logic [31:0] bus_data_o,
  output logic bus_data_oe,
  input wire logic [31:0] bus_data_i,
  input wire logic port_ack_hi_n,
  input wire logic port_ack_lo_n
);
  import dbs_pkg::*;

  dbs_state_t state_r;
  dbs_state_t state_nxt;
  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic [31:0] opnd_r;
  logic [31:0] opnd_nxt;
  logic [31:0] dout_r;
  logic [2:0] left_r;
  logic [2:0] left_nxt;
  logic write_r;
  logic write_nxt;
  logic done_r;

  dbs_mux_if mx();

  dbs_wr_mux u_wr (
    .mx(mx.wr)
  );

  dbs_rd_mux u_rd (
    .mx(mx.rd)
  );

  // mux inputs
  assign mx.siz = left_r[1:0];
  assign mx.ofs = addr_r[1:0];
  assign mx.ack = {port_ack_hi_n, port_ack_lo_n};
  assign mx.opnd = opnd_r;
  assign mx.lanes_in = bus_data_i;

  // handshake decode
  wire take = req_valid && req_ready;
  wire in_strobe = (state_r == ST_STROBE);
  wire acked = in_strobe && (mx.ack != ACK_WAIT);
  wire last = acked && (mx.cnt == left_r);
  wire [2:0] req_bytes = {req_size == SIZ_LONG, req_size};
  wire [31:0] req_opnd = req_write ? req_wdata : DATA_RST;

  // next values
  assign addr_nxt = take ? req_addr :
                    acked ? addr_r + 32'(mx.cnt) : addr_r;
  assign left_nxt = take ? req_bytes :
                    acked ? left_r - mx.cnt : left_r;
  assign opnd_nxt = take ? req_opnd :
                    (acked && !write_r) ? mx.merged : opnd_r;
  assign write_nxt = take ? req_write : write_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_nxt = ST_STROBE;
      end
      ST_STROBE: begin
        // partial acceptance runs a further cycle
        if (last) begin
          state_nxt = ST_IDLE;
        end else if (acked) begin
          state_nxt = ST_SETUP;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      addr_r <= ADDR_RST;
      left_r <= LEFT_RST;
      opnd_r <= DATA_RST;
      write_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      opnd_r <= opnd_nxt;
      write_r <= write_nxt;
    end
  end

  // lane data settles during setup, stable while strobed
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dout_r <= DATA_RST;
      done_r <= 1'b0;
    end else begin
      dout_r <= mx.lanes_out;
      done_r <= last;
    end
  end

  // outputs
  assign req_ready = (state_r == ST_IDLE);
  assign resp_done = done_r;
  assign resp_rdata = opnd_r;
  assign bus_addr = addr_r;
  assign remaining_size_hi = left_r[1];
  assign remaining_size_lo = left_r[0];
  assign bus_strobe = in_strobe;
  assign bus_read = !write_r;
  assign bus_data_o = dout_r;
  assign bus_data_oe = in_strobe && write_r;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  wire [2:0] first_w = 3'h4 - left_r;

  sequence s_long_half;
    in_strobe && write_r && left_r == 3'h4 && addr_r[1:0] == 2'h0
      && mx.ack == ACK_PORT16;
  endsequence

  sequence s_word_rest;
    state_r == ST_SETUP ##1 in_strobe && left_r == 3'h2
      && addr_r[1:0] == 2'h2 && bus_data_o[31:16] == opnd_r[15:0];
  endsequence

  sequence s_word_to_byte;
    in_strobe && write_r && left_r == 3'h2 && mx.ack == ACK_PORT8;
  endsequence

  sequence s_one_left;
    ##2 in_strobe && left_r == 3'h1 && bus_data_o[31:24] == opnd_r[7:0];
  endsequence

  size_pins_match_a: assert property (
    in_strobe |-> left_r != 3'h0
      && {remaining_size_hi, remaining_size_lo} == left_r[1:0])
    else $error("size pins do not match bytes remaining");

  bytes_bound_a: assert property (
    acked |-> mx.cnt != 3'h0 && mx.cnt <= left_r)
    else $error("accepted bytes outside signalled size");

  base_boundary_a: assert property (
    acked && mx.ack == ACK_PORT32 && !last |=> ##1 bus_addr[1:0] == 2'h0)
    else $error("long port continuation not on long-word base");

  addr_step_a: assert property (
    acked |=> addr_r == $past(addr_r) + 32'($past(mx.cnt)))
    else $error("address did not advance by accepted bytes");

  top_lane_a: assert property (
    in_strobe && write_r && left_r == 3'h4 && addr_r[1:0] == 2'h0
      |-> bus_data_o == opnd_r && bus_data_oe)
    else $error("aligned long word not placed msb first");

  word_repl_a: assert property (
    in_strobe && write_r && left_r == 3'h2 && addr_r[1:0] == 2'h1
      |-> bus_data_o[31:24] == opnd_r[15:8]
        && bus_data_o[23:16] == opnd_r[15:8]
        && bus_data_o[15:8] == opnd_r[7:0])
    else $error("odd word write lanes wrong");

  byte_repl_a: assert property (
    in_strobe && write_r |-> bus_data_o[31:24] == opnd_r[31 - 8 * first_w[1:0] -: 8])
    else $error("top lane does not carry first remaining byte");

  half_then_rest_a: assert property (
    s_long_half |=> s_word_rest)
    else $error("word port long write did not continue as one word");

  byte_split_a: assert property (
    s_word_to_byte |-> s_one_left)
    else $error("word to byte port did not move one byte per cycle");

  read_latch_a: assert property (
    acked && !write_r && mx.ack == ACK_PORT8 && left_r == 3'h1
      |=> opnd_r[7:0] == $past(bus_data_i[31:24]))
    else $error("byte port read not taken from top lane");

  wait_hold_a: assert property (
    in_strobe && mx.ack == ACK_WAIT |=> in_strobe && $stable(left_r) && $stable(addr_r))
    else $error("wait ack did not hold the cycle");

  finish_a: assert property (
    last |=> resp_done && req_ready && left_r == 3'h0)
    else $error("transfer did not finish after final ack");

  gap_between_a: assert property (
    acked && !last |=> !bus_strobe ##1 bus_strobe)
    else $error("no strobe gap between cycles");

  addr_load_a: assert property (
    take |=> bus_addr == $past(req_addr))
    else $error("request address not loaded");

  size_load_a: assert property (
    take |=> {remaining_size_hi, remaining_size_lo} == $past(req_size))
    else $error("size pins not loaded from request");

  three_size_a: assert property (
    in_strobe && left_r == 3'h3 |-> remaining_size_hi && remaining_size_lo)
    else $error("three bytes left not shown as 11");

  msb_top_a: assert property (
    in_strobe && write_r && left_r == 3'h4 |-> bus_data_o[31:24] == opnd_r[31:24])
    else $error("long operand msb not on top lane");

  long_odd_a: assert property (
    in_strobe && write_r && left_r == 3'h4 && addr_r[1:0] == 2'h1
      |-> bus_data_o == {opnd_r[31:24], opnd_r[31:8]})
    else $error("odd long write lanes wrong");

  three_even_a: assert property (
    in_strobe && write_r && left_r == 3'h3 && addr_r[1:0] == 2'h2
      |-> bus_data_o == {opnd_r[23:8], opnd_r[23:8]})
    else $error("even three byte write lanes wrong");

  word_even_a: assert property (
    in_strobe && write_r && left_r == 3'h2 && addr_r[1:0] == 2'h2
      |-> bus_data_o == {opnd_r[15:0], opnd_r[15:0]})
    else $error("even word write lanes wrong");

  byte_odd_a: assert property (
    in_strobe && write_r && left_r == 3'h1 && addr_r[1:0] == 2'h1
      |-> bus_data_o[31:16] == {2{opnd_r[7:0]}})
    else $error("odd byte write lanes wrong");

  data_hold_a: assert property (
    in_strobe && !acked |=> $stable(bus_data_o) && $stable(bus_data_oe))
    else $error("lane data changed inside a bus cycle");

  oe_write_a: assert property (
    bus_data_oe |-> bus_strobe && !bus_read)
    else $error("data driven outside a write cycle");

  word_port_a: assert property (
    acked && mx.ack == ACK_PORT16 |-> mx.cnt <= 3'h2)
    else $error("word port moved more than two bytes");

  byte_port_a: assert property (
    acked && mx.ack == ACK_PORT8 |-> mx.cnt == 3'h1)
    else $error("byte port moved other than one byte");

  aligned_long_a: assert property (
    acked && mx.ack == ACK_PORT32 && addr_r[1:0] == 2'h0 |-> last)
    else $error("aligned long port cycle did not finish");

  long_read_a: assert property (
    acked && !write_r && mx.ack == ACK_PORT32 && left_r == 3'h4 && addr_r[1:0] == 2'h0
      |=> opnd_r == $past(bus_data_i))
    else $error("aligned long read not taken from all lanes");

  odd_read_a: assert property (
    acked && !write_r && mx.ack == ACK_PORT16 && left_r == 3'h1 && addr_r[0]
      |=> opnd_r[7:0] == $past(bus_data_i[23:16]))
    else $error("odd byte read not taken from second lane");

  opnd_hold_a: assert property (
    !acked && !take |=> $stable(opnd_r))
    else $error("operand changed without a take or ack");

  setup_ignore_a: assert property (
    state_r == ST_SETUP |=> in_strobe && $stable(addr_r) && $stable(left_r))
    else $error("setup cycle did not lead to a steady strobe");

  start_order_a: assert property (
    take |=> !req_ready ##1 bus_strobe)
    else $error("request did not start a bus cycle");

  done_pulse_a: assert property (
    resp_done |=> !resp_done)
    else $error("done held longer than one cycle");
endmodule

// ===== rtl/dbs_rd_mux.sv
// read-side lane mux: merges accepted lanes into the operand
// assumes ack is the sampled acknowledge pair of the current cycle
`timescale 1ns/1ns
module dbs_rd_mux (
  dbs_mux_if.rd mx
);
  import dbs_pkg::*;
  logic [1:0] first;
  logic [1:0] start;
  logic [2:0] width;
  logic [2:0] avail;
  logic [2:0] left;
  assign first = 2'h0 - mx.siz;
  assign left = {mx.siz == SIZ_LONG, mx.siz};
  // fixed lanes per port width
  assign start = (mx.ack == ACK_PORT32) ? mx.ofs :
                 (mx.ack == ACK_PORT16) ? {1'b0, mx.ofs[0]} : 2'h0;
  assign width = (mx.ack == ACK_PORT32) ? LANES_32 :
                 (mx.ack == ACK_PORT16) ? LANES_16 : LANES_8;
  assign avail = width - {1'b0, start};
  // bytes accepted never exceed what was signalled
  assign mx.cnt = (left < avail) ? left : avail;
  genvar j;
  for (j = 0; j < 4; j++) begin : g_byte
    logic [1:0] rel;
    logic [1:0] lane;
    logic hit;
    assign rel = 2'(j) - first;
    assign lane = start + rel;
    assign hit = (2'(j) >= first) && ({1'b0, rel} < mx.cnt);
    assign mx.merged[31 - 8 * j -: 8] =
      hit ? mx.lanes_in[31 - 8 * lane -: 8] : mx.opnd[31 - 8 * j -: 8];
  end
endmodule

// ===== rtl/dbs_wr_mux.sv
// write-side lane mux: replicates operand bytes onto all four lanes
// assumes siz and ofs come from registers of the sequencer
`timescale 1ns/1ns
module dbs_wr_mux (
  dbs_mux_if.wr mx
);
  import dbs_pkg::*;
  logic [1:0] first;
  logic [1:0] sel [4];
  // first operand byte still to move
  assign first = 2'h0 - mx.siz;
  // top lane always carries the first byte, for byte ports
  assign sel[0] = first;
  assign sel[1] = mx.ofs[0] ? first : first + 2'h1;
  assign sel[2] = (mx.ofs == 2'h3) ? first : first + 2'h2 - mx.ofs;
  assign sel[3] = first + 2'h3 - mx.ofs;
  genvar k;
  for (k = 0; k < 4; k++) begin : g_lane
    assign mx.lanes_out[31 - 8 * k -: 8] = mx.opnd[31 - 8 * sel[k] -: 8];
  end
endmodule

// ===== test/dbs_slave.sv
// far-side slave: 64-byte memory on the fixed lanes of a chosen port width
// assumes the master holds address, size and data through the strobe
`timescale 1ns/1ns
module dbs_slave (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] port_sel,
  input wire logic [1:0] waits,
  input wire logic bus_strobe,
  input wire logic bus_read,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] siz,
  input wire logic [31:0] bus_data_o,
  output logic [31:0] bus_data_i,
  output logic port_ack_hi_n,
  output logic port_ack_lo_n
);
  import dbs_pkg::*;
  logic [7:0] mem [0:63];
  logic [1:0] wait_r;
  logic tick_r = 1'b0;
  int rem, lane0, lanes, n;
  initial for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 11);
  always_comb begin
    rem = (siz == 2'h0) ? 4 : int'(siz);
    lanes = (port_sel == 2'h0) ? 4 : (port_sel == 2'h1) ? 2 : 1;
    lane0 = (port_sel == 2'h0) ? int'(bus_addr[1:0]) : (port_sel == 2'h1) ? int'(bus_addr[0]) : 0;
    n = (rem < lanes - lane0) ? rem : lanes - lane0;
    // unused lanes toggle so stale values never pass
    bus_data_i = {4{tick_r ? 8'h5a : 8'ha5}};
    if (bus_strobe && bus_read)
      for (int k = 0; k < n; k++)
        bus_data_i[31 - 8 * (lane0 + k) -: 8] = mem[6'(bus_addr + k)];
  end
  always @(posedge core_clk) begin
    tick_r <= ~tick_r;
    if (reset) begin
      {port_ack_hi_n, port_ack_lo_n} <= ACK_WAIT;
      wait_r <= 2'h0;
    end else if ({port_ack_hi_n, port_ack_lo_n} != ACK_WAIT) begin
      {port_ack_hi_n, port_ack_lo_n} <= ACK_WAIT;
      wait_r <= 2'h0;
      if (!bus_read)
        for (int k = 0; k < n; k++)
          mem[6'(bus_addr + k)] <= bus_data_o[31 - 8 * (lane0 + k) -: 8];
    end else if (bus_strobe) begin
      if (wait_r == waits)
        {port_ack_hi_n, port_ack_lo_n} <= (port_sel == 2'h0) ? ACK_PORT32 :
          (port_sel == 2'h1) ? ACK_PORT16 : ACK_PORT8;
      else
        wait_r <= wait_r + 2'h1;
    end
  end
endmodule

// ===== test/tb_top.sv
// testbench: byte-memory model against the sequencer over all sizes, offsets, ports
// assumes the slave model in dbs_slave.sv
`timescale 1ns/1ns
module tb_top;
  import dbs_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_ready, resp_done, bus_strobe, bus_read, bus_data_oe;
  logic remaining_size_hi, remaining_size_lo, port_ack_hi_n, port_ack_lo_n;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
  logic [31:0] resp_rdata, bus_addr, bus_data_o, bus_data_i;
  dbs_siz_t req_size = SIZ_LONG;
  logic [1:0] port_sel = 2'h0, waits = 2'h0;
  logic [7:0] mem [0:63];
  logic [5:0] a;
  logic prev_stb = 1'b0, cur_wr = 1'b0;
  int exp_q[$];
  int top_q[$];
  int e, bad_count = 0, checks_done = 0;
  always #20 core_clk = ~core_clk;
  dbs_data_mux u_dbs_data_mux (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
    .req_wdata(req_wdata), .resp_done(resp_done), .resp_rdata(resp_rdata),
    .bus_addr(bus_addr), .remaining_size_hi(remaining_size_hi),
    .remaining_size_lo(remaining_size_lo), .bus_strobe(bus_strobe), .bus_read(bus_read),
    .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe), .bus_data_i(bus_data_i),
    .port_ack_hi_n(port_ack_hi_n), .port_ack_lo_n(port_ack_lo_n));
  dbs_slave u_dbs_slave (.core_clk(core_clk), .reset(reset), .port_sel(port_sel),
    .waits(waits), .bus_strobe(bus_strobe), .bus_read(bus_read), .bus_addr(bus_addr),
    .siz({remaining_size_hi, remaining_size_lo}), .bus_data_o(bus_data_o),
    .bus_data_i(bus_data_i), .port_ack_hi_n(port_ack_hi_n), .port_ack_lo_n(port_ack_lo_n));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // model: expected bus cycles, memory update and read result
  task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] wd);
    int n, rem, lanes, s, acc, t;
    logic [5:0] p;
    logic [31:0] exp;
    n = (sz == SIZ_LONG) ? 4 : int'(sz);
    rem = n;
    p = a;
    exp = 32'h0;
    lanes = (port_sel == 2'h0) ? 4 : (port_sel == 2'h1) ? 2 : 1;
    while (rem > 0) begin
      s = (port_sel == 2'h0) ? int'(p[1:0]) : (port_sel == 2'h1) ? int'(p[0]) : 0;
      exp_q.push_back(int'(p) * 8 + rem);
      top_q.push_back(int'(wd[8 * (rem - 1) +: 8]));
      acc = (rem < lanes - s) ? rem : lanes - s;
      rem -= acc;
      p += 6'(acc);
    end
    for (int i = 0; i < n; i++)
      if (wr)
        mem[a + 6'(i)] = wd[8 * (n - 1 - i) +: 8];
      else
        exp[8 * (n - 1 - i) +: 8] = mem[a + 6'(i)];
    cur_wr = wr;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_size = sz;
    req_addr = {26'h0, a};
    req_wdata = wd;
    @(negedge core_clk);
    req_valid = 1'b0;
    t = 0;
    while (resp_done !== 1'b1 && t < 200) begin
      @(negedge core_clk);
      t++;
    end
    chk("done", {31'h0, resp_done}, 32'h1);
    if (!wr)
      chk("rdata", resp_rdata, exp);
    chk("cycles_left", 32'(exp_q.size()), 32'h0);
    chk("ready", {31'h0, req_ready}, 32'h1);
    exp_q.delete();
    top_q.delete();
  endtask
  always @(negedge core_clk) begin
    prev_stb <= bus_strobe;
    if (bus_strobe === 1'b1 && prev_stb === 1'b0) begin
      chk("extra_cycle", 32'(exp_q.size() > 0), 32'h1);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk("size", {30'h0, remaining_size_hi, remaining_size_lo}, 32'(e % 8 % 4));
        chk("addr", bus_addr, 32'(e / 8));
        chk("oe", {31'h0, bus_data_oe}, {31'h0, cur_wr});
        chk("busy", {31'h0, req_ready}, 32'h0);
        chk("read", {31'h0, bus_read}, {31'h0, !cur_wr});
        e = top_q.pop_front();
        if (cur_wr)
          chk("top_lane", {24'h0, bus_data_o[31:24]}, 32'(e));
      end
    end
  end
  initial begin
    for (int i = 0; i < 64; i++)
      mem[i] = 8'(i * 37 + 11);
    void'($urandom(32'h49652e15));
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    for (int pt = 0; pt < 3; pt++)
      for (int sz = 0; sz < 4; sz++)
        for (int of = 0; of < 4; of++) begin
          port_sel = 2'(pt);
          waits = 2'($urandom_range(0, 2));
          a = {4'($urandom_range(0, 14)), 2'(of)};
          xfer(1'b1, 2'(sz), $urandom);
          port_sel = 2'((pt + 1) % 3);
          xfer(1'b0, 2'(sz), 32'h0);
        end
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
endmodule
